//--- ccri_edge.sv
// rising edge detector for a group of level flags
`timescale 1ns/1ps
`default_nettype none

module ccri_edge #(
	parameter int unsigned W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] level,
	output logic      [W-1:0] rise
);
	logic [W-1:0] prev_q;
	logic [W-1:0] prev_d;

	always_comb begin
		prev_d = level;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
		end else begin
			prev_q <= prev_d;
		end
	end

	assign rise = level & ~prev_q;

	AST_EDGE_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
		(level == $past(level)) |-> (rise == '0))
	else $error("flag held high produced another pulse");
endmodule

`default_nettype wire

//--- ccri_pkg.sv
// types shared by the calendar clock modules
package ccri_pkg;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [2:0] wday;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} ccri_time_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} ccri_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccri_apb_rsp_t;

	typedef struct packed {
		ccri_time_t        run;
		ccri_time_t        cur;
		logic [6:0][15:0]  nreg;
		logic [3:0]        ctrl;
		logic [4:0]        stat;
		logic [4:0]        mask;
		logic [15:0]       scan;
		logic [9:0]        ms;
		logic [15:0]       snap;
		logic              bk_s1;
		logic              bk_s2;
		ccri_apb_rsp_t     rsp;
		logic              irq;
	} ccri_state_t;

endpackage

//--- ccri_regs.svh
// register map, field positions, reset values and timing counts of the calendar clock
`ifndef CCRI_REGS_SVH
`define CCRI_REGS_SVH

// clock and time base
`define CCRI_CLK_PERIOD_NS 100
`define CCRI_MS_NS         1000000
`define CCRI_MS_CYCLES     (`CCRI_MS_NS / `CCRI_CLK_PERIOD_NS)
`define CCRI_SEC_MS        10'h3e7
`define CCRI_SNAP_MS       16'h01f4

// byte offsets; the two bank bases are values of address bits 7:5
`define CCRI_CUR_BASE 3'h0
`define CCRI_NEW_BASE 3'h1
`define CCRI_CTRL_OFS 8'h40
`define CCRI_STAT_OFS 8'h44
`define CCRI_MASK_OFS 8'h48
`define CCRI_SCAN_OFS 8'h4c

// word index inside the current and new banks
`define CCRI_F_YEAR   3'h0
`define CCRI_F_MONTH  3'h1
`define CCRI_F_DAY    3'h2
`define CCRI_F_WDAY   3'h3
`define CCRI_F_HOUR   3'h4
`define CCRI_F_MINUTE 3'h5
`define CCRI_F_SECOND 3'h6
`define CCRI_F_COUNT  3'h7

// control bits; bit 4 is the synced backup-loss flag, not a ctrl bit
`define CCRI_C_CAL  0
`define CCRI_C_TIME 1
`define CCRI_C_COMB 2
`define CCRI_C_ADJ  3
`define CCRI_C_BKUP 4

// status bits
`define CCRI_S_LOAD 0
`define CCRI_S_ADJ  1
`define CCRI_S_ERR  2
`define CCRI_S_INIT 3
`define CCRI_S_SNAP 4

// field limits
`define CCRI_YEAR_MAX  16'h0063
`define CCRI_MONTH_MAX 16'h000c
`define CCRI_DAY_MAX   16'h001f
`define CCRI_WDAY_MAX  16'h0006
`define CCRI_HOUR_MAX  16'h0017
`define CCRI_MS_MAX    16'h003b
`define CCRI_ADJ_HALF  6'h1e

// epoch after backup loss: 2000-01-01 00:00:00, a saturday
`define CCRI_EPOCH_YEAR  7'h00
`define CCRI_EPOCH_MONTH 4'h1
`define CCRI_EPOCH_DAY   5'h01
`define CCRI_EPOCH_WDAY  3'h6

`endif

//--- ccri_tick.sv
// millisecond strobe from the bus clock
`timescale 1ns/1ps
`default_nettype none

module ccri_tick #(
	parameter int unsigned CYCLES = 2
) (
	input  wire logic pclk,
	input  wire logic presetn,
	output logic      pulse
);
	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          pulse_q;
	logic          pulse_d;

	always_comb begin
		pulse_d = 1'b0;
		cnt_d   = cnt_q + 1'b1;
		if (cnt_q == CW'(CYCLES - 1)) begin
			cnt_d   = '0;
			pulse_d = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q   <= '0;
			pulse_q <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			pulse_q <= pulse_d;
		end
	end

	assign pulse = pulse_q;

	AST_TICK_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
		pulse_q |-> (cnt_q == '0))
	else $error("millisecond strobe out of step with its counter");
endmodule

`default_nettype wire

//--- ccri_top.sv
// calendar and time-of-day clock behind an apb register file
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccri_regs.svh"

module ccri_top #(
	parameter int unsigned MS_CYCLES = `CCRI_MS_CYCLES
) (
	input  wire ccri_pkg::ccri_apb_req_t apb_req,
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    backup_lost,
	output var  ccri_pkg::ccri_apb_rsp_t apb_rsp,
	output logic                         irq
);
	ccri_pkg::ccri_state_t s_q;
	ccri_pkg::ccri_state_t s_d;
	logic [4:0]            rise;
	logic                  ms_pulse;
	logic                  sec_tick;
	logic                  cal_go;
	logic                  tim_go;
	logic                  adj_go;
	logic                  bk_go;
	logic                  cal_ok;
	logic                  tim_ok;
	logic                  snap_fire;
	logic [15:0]           snap_len;

	ccri_edge #(.W(5)) u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.level   ({s_q.bk_s2, s_q.ctrl}),
		.rise    (rise)
	);

	ccri_tick #(.CYCLES(MS_CYCLES)) u_tick (
		.pclk    (pclk),
		.presetn (presetn),
		.pulse   (ms_pulse)
	);

	function automatic logic [4:0] days_in(input logic [3:0] m, input logic [6:0] y);
		case (m)
			4'h2:    days_in = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
			4'h4,
			4'h6,
			4'h9,
			4'hb:    days_in = 5'h1e;
			default: days_in = 5'h1f;
		endcase
	endfunction

	// carry chain; skip_sec starts the count at the minute
	function automatic ccri_pkg::ccri_time_t advance(input ccri_pkg::ccri_time_t t,
			input logic skip_sec);
		ccri_pkg::ccri_time_t n;
		logic                 c;
		n = t;
		c = 1'b1;
		if (!skip_sec) begin
			c        = (t.second == 6'h3b);
			n.second = c ? 6'h00 : t.second + 6'h01;
		end
		if (c) begin
			c        = (t.minute == 6'h3b);
			n.minute = c ? 6'h00 : t.minute + 6'h01;
		end
		if (c) begin
			c      = (t.hour == 5'h17);
			n.hour = c ? 5'h00 : t.hour + 5'h01;
		end
		if (c) begin
			n.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
			// >= keeps a loaded day 31 of a short month from running on
			c      = (t.day >= days_in(t.month, t.year));
			n.day  = c ? 5'h01 : t.day + 5'h01;
		end
		if (c) begin
			c       = (t.month == 4'hc);
			n.month = c ? 4'h1 : t.month + 4'h1;
		end
		if (c) begin
			n.year = (t.year == 7'h63) ? 7'h00 : t.year + 7'h01;
		end
		return n;
	endfunction

	function automatic logic [15:0] field(input ccri_pkg::ccri_time_t t, input logic [2:0] i);
		case (i)
			`CCRI_F_YEAR:   field = {9'h0, t.year};
			`CCRI_F_MONTH:  field = {12'h0, t.month};
			`CCRI_F_DAY:    field = {11'h0, t.day};
			`CCRI_F_WDAY:   field = {13'h0, t.wday};
			`CCRI_F_HOUR:   field = {11'h0, t.hour};
			`CCRI_F_MINUTE: field = {10'h0, t.minute};
			`CCRI_F_SECOND: field = {10'h0, t.second};
			default:        field = 16'h0000;
		endcase
	endfunction

	assign cal_go   = rise[`CCRI_C_CAL] | rise[`CCRI_C_COMB];
	assign tim_go   = rise[`CCRI_C_TIME] | rise[`CCRI_C_COMB];
	assign adj_go   = rise[`CCRI_C_ADJ];
	assign bk_go    = rise[`CCRI_C_BKUP];
	assign sec_tick = ms_pulse & (s_q.ms == `CCRI_SEC_MS);

	// values outside their range are refused
	assign cal_ok = (s_q.nreg[`CCRI_F_YEAR] <= `CCRI_YEAR_MAX)
		&& (s_q.nreg[`CCRI_F_MONTH] >= 16'h0001) && (s_q.nreg[`CCRI_F_MONTH] <= `CCRI_MONTH_MAX)
		&& (s_q.nreg[`CCRI_F_DAY] >= 16'h0001) && (s_q.nreg[`CCRI_F_DAY] <= `CCRI_DAY_MAX)
		&& (s_q.nreg[`CCRI_F_WDAY] <= `CCRI_WDAY_MAX);
	assign tim_ok = (s_q.nreg[`CCRI_F_HOUR] <= `CCRI_HOUR_MAX)
		&& (s_q.nreg[`CCRI_F_MINUTE] <= `CCRI_MS_MAX)
		&& (s_q.nreg[`CCRI_F_SECOND] <= `CCRI_MS_MAX);

	// a scan period of 500 ms or more sets the copy interval
	assign snap_len  = (s_q.scan >= `CCRI_SNAP_MS) ? s_q.scan : `CCRI_SNAP_MS;
	assign snap_fire = ms_pulse & ((s_q.snap + 16'h0001) >= snap_len);

	always_comb begin
		logic        acc;
		logic        hit;
		logic        wr;
		logic [2:0]  idx;
		logic [31:0] rdata;
		logic [4:0]  set;
		logic [4:0]  clr;
		ccri_pkg::ccri_time_t t;
		acc   = 1'b0;
		hit   = 1'b0;
		wr    = 1'b0;
		idx   = 3'h0;
		rdata = 32'h0000_0000;
		set   = 5'h00;
		clr   = 5'h00;
		t     = s_q.run;
		s_d   = s_q;

		s_d.bk_s1 = backup_lost;
		s_d.bk_s2 = s_q.bk_s1;

		// apb decode; new registers read back as zero
		idx = apb_req.paddr[4:2];
		acc = apb_req.psel & apb_req.penable;
		if (apb_req.paddr[1:0] == 2'h0) begin
			if (apb_req.paddr[7:5] == `CCRI_CUR_BASE && idx != `CCRI_F_COUNT) begin
				hit   = 1'b1;
				rdata = {16'h0000, field(s_q.cur, idx)};
			end else if (apb_req.paddr[7:5] == `CCRI_NEW_BASE && idx != `CCRI_F_COUNT) begin
				hit = 1'b1;
			end else begin
				case (apb_req.paddr)
					`CCRI_CTRL_OFS: begin
						hit   = 1'b1;
						rdata = {28'h0, s_q.ctrl};
					end
					`CCRI_STAT_OFS: begin
						hit   = 1'b1;
						rdata = {27'h0, s_q.stat};
					end
					`CCRI_MASK_OFS: begin
						hit   = 1'b1;
						rdata = {27'h0, s_q.mask};
					end
					`CCRI_SCAN_OFS: begin
						hit   = 1'b1;
						rdata = {16'h0000, s_q.scan};
					end
					default: hit = 1'b0;
				endcase
			end
		end
		// one wait state: pready rises on the second access cycle
		s_d.rsp.pready = acc & ~s_q.rsp.pready;
		if (acc && !s_q.rsp.pready) begin
			s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rdata;
			s_d.rsp.pslverr = ~hit;
		end
		wr = acc & s_q.rsp.pready & apb_req.pwrite & hit;
		if (wr) begin
			if (apb_req.paddr[7:5] == `CCRI_NEW_BASE) begin
				s_d.nreg[idx] = apb_req.pwdata[15:0];
			end
			case (apb_req.paddr)
				`CCRI_CTRL_OFS: s_d.ctrl = apb_req.pwdata[3:0];
				`CCRI_STAT_OFS: clr = apb_req.pwdata[4:0];
				`CCRI_MASK_OFS: s_d.mask = apb_req.pwdata[4:0];
				`CCRI_SCAN_OFS: s_d.scan = apb_req.pwdata[15:0];
				default: clr = 5'h00;
			endcase
		end

		// free running time base
		if (ms_pulse) begin
			s_d.ms = (s_q.ms == `CCRI_SEC_MS) ? 10'h000 : s_q.ms + 10'h001;
		end
		if (sec_tick) begin
			t = advance(s_q.run, 1'b0);
		end

		if (bk_go) begin
			t        = '0;
			t.year   = `CCRI_EPOCH_YEAR;
			t.month  = `CCRI_EPOCH_MONTH;
			t.day    = `CCRI_EPOCH_DAY;
			t.wday   = `CCRI_EPOCH_WDAY;
			s_d.ms   = 10'h000;
			set[`CCRI_S_INIT] = 1'b1;
		end else if ((cal_go && !cal_ok) || (tim_go && !tim_ok)
				|| (adj_go && (cal_go || tim_go))) begin
			set[`CCRI_S_ERR] = 1'b1;
		end else begin
			if (tim_go) begin
				t        = s_q.run;
				t.hour   = s_q.nreg[`CCRI_F_HOUR][4:0];
				t.minute = s_q.nreg[`CCRI_F_MINUTE][5:0];
				t.second = s_q.nreg[`CCRI_F_SECOND][5:0];
				s_d.ms   = 10'h000;
			end
			if (cal_go) begin
				t.year  = s_q.nreg[`CCRI_F_YEAR][6:0];
				t.month = s_q.nreg[`CCRI_F_MONTH][3:0];
				t.day   = s_q.nreg[`CCRI_F_DAY][4:0];
				t.wday  = s_q.nreg[`CCRI_F_WDAY][2:0];
			end
			if (cal_go || tim_go) begin
				set[`CCRI_S_LOAD] = 1'b1;
			end
			if (adj_go) begin
				t        = (s_q.run.second >= `CCRI_ADJ_HALF) ? advance(s_q.run, 1'b1) : s_q.run;
				t.second = 6'h00;
				s_d.ms   = 10'h000;
				set[`CCRI_S_ADJ] = 1'b1;
			end
		end
		s_d.run = t;

		// periodic copy to the read-only bank
		if (ms_pulse) begin
			s_d.snap = snap_fire ? 16'h0000 : s_q.snap + 16'h0001;
		end
		if (snap_fire) begin
			s_d.cur = s_q.run;
			set[`CCRI_S_SNAP] = 1'b1;
		end

		// a new event beats a clear in the same cycle
		s_d.stat = (s_q.stat & ~clr) | set;
		s_d.irq  = |(s_d.stat & s_d.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q           <= '0;
			s_q.run.month <= `CCRI_EPOCH_MONTH;
			s_q.run.day   <= `CCRI_EPOCH_DAY;
			s_q.run.wday  <= `CCRI_EPOCH_WDAY;
			s_q.cur.month <= `CCRI_EPOCH_MONTH;
			s_q.cur.day   <= `CCRI_EPOCH_DAY;
			s_q.cur.wday  <= `CCRI_EPOCH_WDAY;
		end else begin
			s_q <= s_d;
		end
	end

	assign apb_rsp = s_q.rsp;
	assign irq     = s_q.irq;

	sequence seq_adj_low;
		adj_go && !bk_go && !cal_go && !tim_go && (s_q.run.second < `CCRI_ADJ_HALF);
	endsequence

	sequence seq_adj_high;
		adj_go && !bk_go && !cal_go && !tim_go && (s_q.run.second >= `CCRI_ADJ_HALF);
	endsequence

	AST_CAL_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(cal_go && !tim_go && cal_ok && !bk_go && !adj_go) |=>
		(s_q.run.year == $past(s_q.nreg[0][6:0])) && (s_q.run.wday == $past(s_q.nreg[3][2:0])))
	else $error("calendar load did not take the new date");

	AST_TIME_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(tim_go && !cal_go && tim_ok && !bk_go && !adj_go) |=>
		(s_q.run.hour == $past(s_q.nreg[4][4:0])) && (s_q.run.second == $past(s_q.nreg[6][5:0]))
		&& (s_q.run.day == $past(s_q.run.day)) && (s_q.run.year == $past(s_q.run.year)))
	else $error("time load wrong or date disturbed");

	AST_COMB_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
		(rise[`CCRI_C_COMB] && cal_ok && tim_ok && !bk_go && !adj_go) |=>
		(s_q.run.month == $past(s_q.nreg[1][3:0])) && (s_q.run.minute == $past(s_q.nreg[5][5:0])))
	else $error("combined load incomplete");

	AST_SNAP_COPY: assert property (@(posedge pclk) disable iff (!presetn)
		snap_fire |=> (s_q.cur == $past(s_q.run)) ##1 (s_q.snap <= 16'h0001))
	else $error("snapshot not copied");

	AST_SNAP_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		!snap_fire |=> $stable(s_q.cur))
	else $error("current bank changed between snapshots");

	AST_RANGES: assert property (@(posedge pclk) disable iff (!presetn)
		(s_q.run.year <= 7'h63) && (s_q.run.month >= 4'h1) && (s_q.run.month <= 4'hc)
		&& (s_q.run.hour <= 5'h17) && (s_q.run.minute <= 6'h3b) && (s_q.run.second <= 6'h3b))
	else $error("running field out of range");

	AST_WDAY: assert property (@(posedge pclk) disable iff (!presetn)
		s_q.run.wday <= 3'h6)
	else $error("weekday code above saturday");

	AST_ADJ_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		seq_adj_low |=> (s_q.run.second == 6'h00) && $stable(s_q.run.minute))
	else $error("low seconds adjust wrong");

	AST_ADJ_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
		seq_adj_high |=> (s_q.run.second == 6'h00)
		&& (s_q.run.minute == (($past(s_q.run.minute) == 6'h3b) ? 6'h00 : $past(s_q.run.minute) + 6'h01)))
	else $error("high seconds adjust did not bump minute");

	AST_EPOCH: assert property (@(posedge pclk) disable iff (!presetn)
		bk_go |=> (s_q.run.year == 7'h00) && (s_q.run.month == 4'h1) && (s_q.run.day == 5'h01)
		&& (s_q.run.hour == 5'h00) && (s_q.run.second == 6'h00) && s_q.stat[`CCRI_S_INIT])
	else $error("backup loss did not restart at the epoch");

	AST_ERR: assert property (@(posedge pclk) disable iff (!presetn)
		(!bk_go && ((cal_go && !cal_ok) || (tim_go && !tim_ok))) |=>
		s_q.stat[`CCRI_S_ERR] && $stable(s_q.run.hour))
	else $error("bad write not flagged");
endmodule

`default_nettype wire

//--- ccri_top_test.sv
// self-checking bench for the calendar clock register file
`timescale 1ns/1ps
`default_nettype none

module ccri_top_test;
	// short ms so a second is 4000 cycles and a copy 2000
	localparam int unsigned MS        = 4;
	localparam int unsigned SNAP_WAIT = 2100;

	logic                    pclk;
	logic                    presetn;
	logic                    backup_lost;
	logic                    irq;
	ccri_pkg::ccri_apb_req_t req;
	ccri_pkg::ccri_apb_rsp_t rsp;
	int                      mismatches;
	int                      check_count;
	logic [31:0]             rdata;
	logic                    rerr;
	logic [15:0]             t [7];

	ccri_top #(.MS_CYCLES(MS)) i_dut (
		.apb_req     (req),
		.pclk        (pclk),
		.presetn     (presetn),
		.backup_lost (backup_lost),
		.apb_rsp     (rsp),
		.irq         (irq)
	);

	always #50 pclk = ~pclk;

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// request held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge pclk);
		req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (rsp.pready !== 1'b1);
		rdata = rsp.prdata;
		rerr = rsp.pslverr;
		// one wait state: answer on the second access edge
		chk("access edges", n, 32'h2);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic set_new(input logic [15:0] v [7]);
		for (int i = 0; i < 7; i++)
			wr(8'h20 + 8'(4 * i), {16'h0000, v[i]});
	endtask

	// first n fields of the current bank compared exactly
	task automatic cur_chk(input logic [15:0] e [7], input int n);
		for (int i = 0; i < n; i++) begin
			xfer(1'b0, 8'(4 * i), 32'h0);
			chk("current field", rdata, {16'h0000, e[i]});
		end
	endtask

	// seconds may have ticked once since the copy
	task automatic sec_low;
		xfer(1'b0, 8'h18, 32'h0);
		chk("current second", 32'(rdata < 32'h2), 32'h1);
	endtask

	initial begin
		repeat (60000) @(posedge pclk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		backup_lost = 1'b0;
		req = '0;
		mismatches = 0;
		check_count = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t = '{16'h0, 16'h1, 16'h1, 16'h6, 16'h0, 16'h0, 16'h0};
		cur_chk(t, 7);
		for (int i = 0; i < 4; i++) begin
			xfer(1'b0, 8'h40 + 8'(4 * i), 32'h0);
			chk("control reset", rdata, 32'h0);
		end
		$display("test reset done");
		t = '{16'h000c, 16'h0002, 16'h0015, 16'h0002, 16'h0009, 16'h0023, 16'h0028};
		set_new(t);
		wr(8'h40, 32'h4);
		repeat (SNAP_WAIT) @(posedge pclk);
		cur_chk(t, 7);
		$display("test combined done");
		t = '{16'h000c, 16'h000c, 16'h001f, 16'h0001, 16'h0017, 16'h003b, 16'h002d};
		set_new(t);
		wr(8'h40, 32'h1);
		repeat (SNAP_WAIT) @(posedge pclk);
		t = '{16'h000c, 16'h000c, 16'h001f, 16'h0001, 16'h0009, 16'h0023, 16'h0};
		cur_chk(t, 6);
		$display("test calendar done");
		wr(8'h20, 32'h32);
		wr(8'h40, 32'h2);
		repeat (SNAP_WAIT) @(posedge pclk);
		t = '{16'h000c, 16'h000c, 16'h001f, 16'h0001, 16'h0017, 16'h003b, 16'h002d};
		cur_chk(t, 7);
		$display("test time done");
		// time flag stays high while the adjust flag rises
		wr(8'h40, 32'ha);
		repeat (SNAP_WAIT) @(posedge pclk);
		t = '{16'h000d, 16'h0001, 16'h0001, 16'h0002, 16'h0, 16'h0, 16'h0};
		cur_chk(t, 6);
		sec_low();
		$display("test adjust done");
		wr(8'h44, 32'h1f);
		wr(8'h24, 32'hd);
		wr(8'h40, 32'h0);
		wr(8'h40, 32'h4);
		xfer(1'b0, 8'h44, 32'h0);
		chk("error status", rdata & 32'h4, 32'h4);
		chk("masked irq", irq, 1'b0);
		wr(8'h48, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq raised", irq, 1'b1);
		wr(8'h44, 32'h4);
		repeat (2) @(posedge pclk);
		chk("irq cleared", irq, 1'b0);
		$display("test error done");
		xfer(1'b0, 8'h80, 32'h0);
		chk("unmapped error", rerr, 1'b1);
		chk("unmapped data", rdata, 32'h0);
		xfer(1'b0, 8'h20, 32'h0);
		chk("new bank read", rdata, 32'h0);
		chk("new bank error", rerr, 1'b0);
		$display("test access done");
		backup_lost <= 1'b1;
		repeat (4) @(posedge pclk);
		backup_lost <= 1'b0;
		repeat (SNAP_WAIT) @(posedge pclk);
		t = '{16'h0, 16'h1, 16'h1, 16'h6, 16'h0, 16'h0, 16'h0};
		cur_chk(t, 6);
		sec_low();
		xfer(1'b0, 8'h44, 32'h0);
		chk("epoch status", rdata & 32'h8, 32'h8);
		$display("test backup done");
		// scan period of 1000 ms stretches the copy interval
		wr(8'h4c, 32'h3e8);
		wr(8'h44, 32'h10);
		do begin
			xfer(1'b0, 8'h44, 32'h0);
		end while (rdata[4] !== 1'b1);
		wr(8'h44, 32'h10);
		repeat (SNAP_WAIT) @(posedge pclk);
		xfer(1'b0, 8'h44, 32'h0);
		chk("no copy at 500 ms", rdata & 32'h10, 32'h0);
		repeat (2000) @(posedge pclk);
		xfer(1'b0, 8'h44, 32'h0);
		chk("copy at scan period", rdata & 32'h10, 32'h10);
		$display("test scan done");
		report_and_stop();
	end
endmodule

`default_nettype wire
